//--- hw/cascade_irq_map.vh
// Port addresses, field positions, reset values and codes for the cascaded interrupt pair
`ifndef CASCADE_IRQ_MAP_VH
`define CASCADE_IRQ_MAP_VH
`define MASTER_BASE_PORT 8'h20
`define MASTER_ODD_PORT 8'h21
`define SLAVE_BASE_PORT 8'ha0
`define SLAVE_ODD_PORT 8'ha1
`define INIT_ONE_BIT 4
`define MODE_RESET 8'h01
`define MASK_RESET 8'h00
`define MODE_AUTO_EOI_BIT 1
`define MODE_SPECIAL_NEST_BIT 4
`define CASCADE_LINE 3'h2
`define CASCADE_RESET 8'h04
`define SLAVE_ID_RESET 8'h02
`define VECTOR_RESET 8'h00
`endif

//--- hw/cascade_irq_setup.v
// Master and slave interrupt controller pair: setup words, masking, vectoring, cascade select
`timescale 1ns/1ps
`include "cascade_irq_map.vh"

module cascade_irq_setup (
    input wire mclk_i,
    input wire rst_i,
    input wire [7:0] io_addr_i,
    input wire [7:0] io_wdata_i,
    input wire io_wr_i,
    input wire io_rd_i,
    input wire [15:0] irq_i,
    input wire interrupt_acknowledge_n_i,
    input wire [7:0] eoi_clear_master_i,
    input wire [7:0] eoi_clear_slave_i,
    output reg [7:0] io_rdata_o,
    output reg io_rdata_oe_o,
    output reg int_o,
    output reg [7:0] ack_data_o,
    output reg ack_data_oe_o,
    output reg [2:0] cascade_code_o,
    output reg master_auto_eoi_o,
    output reg slave_auto_eoi_o,
    output reg master_special_nest_o,
    output reg slave_special_nest_o
);

    localparam [3:0] ST_IDLE = 4'b0001;
    localparam [3:0] ST_BASE = 4'b0010;
    localparam [3:0] ST_CASC = 4'b0100;
    localparam [3:0] ST_MODE = 4'b1000;

    // Lowest-numbered pending line wins; fixed priority only
    function [3:0] pick;
        input [7:0] pend;
        integer k;
        begin
            pick = 4'h8;
            for (k = 7; k >= 0; k = k - 1) begin
                if (pend[k]) begin
                    pick = {1'b0, k[2:0]};
                end
            end
        end
    endfunction

    function [7:0] make_vector;
        input [7:0] base;
        input [2:0] level;
        begin
            make_vector = {base[7:3], level};
        end
    endfunction

    reg [15:0] irq_s1_reg;
    reg [15:0] irq_s2_reg;
    reg [15:0] irq_prev_reg;
    reg [1:0] ack_s_reg;
    reg ack_prev_reg;
    reg [3:0] m_state_reg;
    reg [3:0] s_state_reg;
    reg [7:0] m_base_reg;
    reg [7:0] s_base_reg;
    reg [7:0] m_casc_reg;
    reg [7:0] s_id_reg;
    reg [7:0] m_mode_reg;
    reg [7:0] s_mode_reg;
    reg [7:0] m_mask_reg;
    reg [7:0] s_mask_reg;
    reg [7:0] m_req_reg;
    reg [7:0] s_req_reg;
    reg [7:0] m_isr_reg;
    reg [7:0] s_isr_reg;
    reg [1:0] pulse_cnt_reg;
    reg [2:0] m_level_reg;
    reg [2:0] s_level_reg;
    reg from_slave_reg;

    wire wr_m_even = io_wr_i && io_addr_i == `MASTER_BASE_PORT;
    wire wr_m_odd = io_wr_i && io_addr_i == `MASTER_ODD_PORT;
    wire wr_s_even = io_wr_i && io_addr_i == `SLAVE_BASE_PORT;
    wire wr_s_odd = io_wr_i && io_addr_i == `SLAVE_ODD_PORT;
    wire m_init = wr_m_even && io_wdata_i[`INIT_ONE_BIT];
    wire s_init = wr_s_even && io_wdata_i[`INIT_ONE_BIT];

    wire ack_low = ~ack_s_reg[1];
    wire ack_fall = ack_prev_reg && ack_low;
    wire ack_rise = ~ack_prev_reg && ~ack_low;

    // Rising edges only; a line held high after setup must drop and rise again
    wire [15:0] irq_edge = irq_s2_reg & ~irq_prev_reg;

    wire [7:0] s_pend = s_req_reg & ~s_mask_reg;
    wire [3:0] s_win = pick(s_pend);
    wire s_int = ~s_win[3] && (s_isr_reg == 8'h00);
    // Slave output stands on master line two; master mask bit two blocks it
    wire [7:0] m_in = {m_req_reg[7:3], m_req_reg[2] | s_int, m_req_reg[1:0]};
    wire [7:0] m_pend = m_in & ~m_mask_reg;
    wire [3:0] m_win = pick(m_pend);
    wire m_int = ~m_win[3] && (m_isr_reg == 8'h00);
    wire m_win_casc = m_casc_reg[m_win[2:0]];
    wire slave_hit = cascade_code_o == s_id_reg[2:0];

    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_s1_reg <= 16'h0000;
            irq_s2_reg <= 16'h0000;
            irq_prev_reg <= 16'h0000;
            ack_s_reg <= 2'h3;
            ack_prev_reg <= 1'b1;
        end else begin
            irq_s1_reg <= irq_i;
            irq_s2_reg <= irq_s1_reg;
            irq_prev_reg <= irq_s2_reg;
            ack_s_reg <= {ack_s_reg[0], interrupt_acknowledge_n_i};
            ack_prev_reg <= ack_low ? 1'b0 : 1'b1;
        end
    end

    // Initialization sequence, one per controller
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            m_state_reg <= ST_IDLE;
            s_state_reg <= ST_IDLE;
            m_base_reg <= `VECTOR_RESET;
            s_base_reg <= `VECTOR_RESET;
            m_casc_reg <= `CASCADE_RESET;
            s_id_reg <= `SLAVE_ID_RESET;
            m_mode_reg <= `MODE_RESET;
            s_mode_reg <= `MODE_RESET;
            m_mask_reg <= `MASK_RESET;
            s_mask_reg <= `MASK_RESET;
        end else begin
            if (m_init) begin
                m_state_reg <= ST_BASE;
                m_mask_reg <= `MASK_RESET;
            end else if (wr_m_odd) begin
                case (m_state_reg)
                    ST_BASE: begin
                        m_base_reg <= io_wdata_i;
                        m_state_reg <= ST_CASC;
                    end
                    ST_CASC: begin
                        m_casc_reg <= io_wdata_i;
                        m_state_reg <= ST_MODE;
                    end
                    ST_MODE: begin
                        m_mode_reg <= io_wdata_i;
                        m_state_reg <= ST_IDLE;
                    end
                    ST_IDLE: m_mask_reg <= io_wdata_i;
                    default: m_state_reg <= ST_IDLE;
                endcase
            end
            if (s_init) begin
                s_state_reg <= ST_BASE;
                s_mask_reg <= `MASK_RESET;
            end else if (wr_s_odd) begin
                case (s_state_reg)
                    ST_BASE: begin
                        s_base_reg <= io_wdata_i;
                        s_state_reg <= ST_CASC;
                    end
                    ST_CASC: begin
                        s_id_reg <= io_wdata_i;
                        s_state_reg <= ST_MODE;
                    end
                    ST_MODE: begin
                        s_mode_reg <= io_wdata_i;
                        s_state_reg <= ST_IDLE;
                    end
                    ST_IDLE: s_mask_reg <= io_wdata_i;
                    default: s_state_reg <= ST_IDLE;
                endcase
            end
        end
    end

    // Request and in-service bits; a new edge wins over a same-cycle acknowledge clear, an init clear wins over a new edge
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            m_req_reg <= 8'h00;
            s_req_reg <= 8'h00;
            m_isr_reg <= 8'h00;
            s_isr_reg <= 8'h00;
            pulse_cnt_reg <= 2'h0;
            m_level_reg <= 3'h0;
            s_level_reg <= 3'h0;
            from_slave_reg <= 1'b0;
            cascade_code_o <= 3'h0;
            ack_data_o <= 8'h00;
            ack_data_oe_o <= 1'b0;
        end else begin
            m_req_reg <= m_init ? 8'h00 : m_req_reg | irq_edge[7:0];
            s_req_reg <= s_init ? 8'h00 : s_req_reg | irq_edge[15:8];
            m_isr_reg <= m_init ? 8'h00 : m_isr_reg & ~eoi_clear_master_i;
            s_isr_reg <= s_init ? 8'h00 : s_isr_reg & ~eoi_clear_slave_i;
            if (ack_fall && pulse_cnt_reg == 2'h0) begin
                // First pulse: freeze the winning levels
                m_level_reg <= m_win[2:0];
                s_level_reg <= s_win[2:0];
                from_slave_reg <= m_win_casc;
                m_req_reg[m_win[2:0]] <= irq_edge[m_win[2:0]];
                if (m_win_casc) begin
                    s_req_reg[s_win[2:0]] <= irq_edge[{1'b1, s_win[2:0]}];
                end
            end
            if (ack_rise && pulse_cnt_reg == 2'h0) begin
                pulse_cnt_reg <= 2'h1;
                if (from_slave_reg) begin
                    cascade_code_o <= `CASCADE_LINE;
                end
                m_isr_reg[m_level_reg] <= ~m_mode_reg[`MODE_AUTO_EOI_BIT];
                if (from_slave_reg) begin
                    s_isr_reg[s_level_reg] <= ~s_mode_reg[`MODE_AUTO_EOI_BIT];
                end
            end
            if (ack_fall && pulse_cnt_reg == 2'h1) begin
                ack_data_oe_o <= ~from_slave_reg || slave_hit;
                if (from_slave_reg) begin
                    ack_data_o <= make_vector(s_base_reg, s_level_reg);
                end else begin
                    ack_data_o <= make_vector(m_base_reg, m_level_reg);
                end
            end
            if (ack_rise && pulse_cnt_reg == 2'h1) begin
                pulse_cnt_reg <= 2'h0;
                ack_data_oe_o <= 1'b0;
                cascade_code_o <= 3'h0;
                from_slave_reg <= 1'b0;
            end
        end
    end

    // Mask readback needs no status selection
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            io_rdata_o <= 8'h00;
            io_rdata_oe_o <= 1'b0;
            int_o <= 1'b0;
            master_auto_eoi_o <= 1'b0;
            slave_auto_eoi_o <= 1'b0;
            master_special_nest_o <= 1'b0;
            slave_special_nest_o <= 1'b0;
        end else begin
            io_rdata_oe_o <= io_rd_i &&
                (io_addr_i == `MASTER_ODD_PORT || io_addr_i == `SLAVE_ODD_PORT);
            io_rdata_o <= (io_addr_i == `SLAVE_ODD_PORT) ? s_mask_reg : m_mask_reg;
            int_o <= m_int && pulse_cnt_reg == 2'h0;
            master_auto_eoi_o <= m_mode_reg[`MODE_AUTO_EOI_BIT];
            slave_auto_eoi_o <= s_mode_reg[`MODE_AUTO_EOI_BIT];
            master_special_nest_o <= m_mode_reg[`MODE_SPECIAL_NEST_BIT];
            slave_special_nest_o <= s_mode_reg[`MODE_SPECIAL_NEST_BIT];
        end
    end

endmodule // cascade_irq_setup

//--- sim/cascade_irq_checker.sv
// Port-level assertions for the cascaded interrupt controller pair
`timescale 1ns/1ps
module cascade_irq_checker (
    input wire mclk_i,
    input wire rst_i,
    input wire [7:0] io_addr_i,
    input wire [7:0] io_wdata_i,
    input wire io_wr_i,
    input wire io_rd_i,
    input wire interrupt_acknowledge_n_i,
    input wire io_rdata_oe_o,
    input wire int_o,
    input wire ack_data_oe_o,
    input wire [2:0] cascade_code_o,
    input wire master_auto_eoi_o,
    input wire slave_auto_eoi_o,
    input wire master_special_nest_o,
    input wire slave_special_nest_o
);
reg [1:0] m_step_reg;
reg [1:0] s_step_reg;
wire odd_rd = io_rd_i && (io_addr_i == 8'h21 || io_addr_i == 8'ha1);
// Tracks the setup sequence so the fourth word can be identified
always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
        m_step_reg <= 2'h0;
        s_step_reg <= 2'h0;
    end else if (io_wr_i) begin
        if (io_addr_i == 8'h20 && io_wdata_i[4]) m_step_reg <= 2'h1;
        if (io_addr_i == 8'h21 && m_step_reg != 2'h0) m_step_reg <= m_step_reg + 2'h1;
        if (io_addr_i == 8'ha0 && io_wdata_i[4]) s_step_reg <= 2'h1;
        if (io_addr_i == 8'ha1 && s_step_reg != 2'h0) s_step_reg <= s_step_reg + 2'h1;
    end
end
default clocking @(posedge mclk_i); endclocking
default disable iff (rst_i);
a_read_answer: assert property (odd_rd |=> io_rdata_oe_o)
    else $error("odd port read not answered");
a_read_quiet: assert property (!odd_rd |=> !io_rdata_oe_o)
    else $error("read data enabled without odd port read");
a_vector_in_pulse: assert property ($rose(ack_data_oe_o) |-> !interrupt_acknowledge_n_i)
    else $error("vector driven outside acknowledge pulse");
a_vector_bounded: assert property ($rose(ack_data_oe_o) |-> ##[1:12] !ack_data_oe_o)
    else $error("vector held too long");
a_code_value: assert property (cascade_code_o != 3'h0 |-> cascade_code_o == 3'h2)
    else $error("wrong cascade code");
a_code_ends: assert property ($fell(cascade_code_o == 3'h2) |-> !ack_data_oe_o)
    else $error("vector outlives cascade code");
a_no_int_vector: assert property (ack_data_oe_o |-> !int_o)
    else $error("interrupt raised during vector");
a_mode_reset: assert property ($fell(rst_i) |-> !(master_auto_eoi_o || slave_auto_eoi_o ||
    master_special_nest_o || slave_special_nest_o))
    else $error("mode outputs not at reset value");
a_master_mode: assert property (io_wr_i && io_addr_i == 8'h21 && m_step_reg == 2'h3 |->
    ##2 master_auto_eoi_o == $past(io_wdata_i[1], 2) &&
    master_special_nest_o == $past(io_wdata_i[4], 2)) else $error("master mode not taken");
a_slave_mode: assert property (io_wr_i && io_addr_i == 8'ha1 && s_step_reg == 2'h3 |->
    ##2 slave_auto_eoi_o == $past(io_wdata_i[1], 2) &&
    slave_special_nest_o == $past(io_wdata_i[4], 2)) else $error("slave mode not taken");
c_slave_vector: cover property (ack_data_oe_o && cascade_code_o == 3'h2);
c_master_vector: cover property (ack_data_oe_o && cascade_code_o == 3'h0);
c_mask_read: cover property (odd_rd ##1 io_rdata_oe_o);
endmodule // cascade_irq_checker

//--- sim/host_ack_model.sv
// Host side of the acknowledge link: two low pulses and vector capture
`timescale 1ns/1ps
module host_ack_model (
    input wire mclk_i,
    input wire [7:0] ack_data_i,
    input wire ack_data_oe_i,
    input wire [2:0] cascade_code_i,
    output reg interrupt_acknowledge_n_o
);
initial interrupt_acknowledge_n_o = 1'b1;
// Pulses and gaps of five cycles stay clear of the two-stage synchroniser
task run(output [7:0] vec, output seen, output [2:0] code);
    integer k;
    begin
        vec = 8'h00;
        seen = 1'b0;
        code = 3'h0;
        for (k = 0; k < 26; k = k + 1) begin
            @(posedge mclk_i);
            if (ack_data_oe_i) begin
                vec = ack_data_i;
                seen = 1'b1;
            end
            if (k == 13) code = cascade_code_i;
            #1 interrupt_acknowledge_n_o = (k > 4 && k < 10) || k > 14;
        end
    end
endtask
endmodule // host_ack_model

//--- sim/tb_cascade_irq_setup.sv
// Self-checking bench for the cascaded interrupt controller pair
`timescale 1ns/1ps
module tb_cascade_irq_setup;
reg mclk_i = 1'b0;
reg rst_i = 1'b1;
reg [7:0] io_addr_i = 8'h00;
reg [7:0] io_wdata_i = 8'h00;
reg io_wr_i = 1'b0;
reg io_rd_i = 1'b0;
reg [15:0] irq_i = 16'h0000;
reg [7:0] eoi_clear_master_i = 8'h00;
reg [7:0] eoi_clear_slave_i = 8'h00;
wire interrupt_acknowledge_n_i;
wire [7:0] io_rdata_o, ack_data_o;
wire io_rdata_oe_o, int_o, ack_data_oe_o;
wire [2:0] cascade_code_o;
wire master_auto_eoi_o, slave_auto_eoi_o, master_special_nest_o, slave_special_nest_o;
integer fails = 0, comparisons = 0, cycles = 0, n;
reg [7:0] vec;
reg seen;
reg [2:0] code;
always #2.5 mclk_i = ~mclk_i;
cascade_irq_setup i_dut (.*);
host_ack_model i_host (.mclk_i(mclk_i), .ack_data_i(ack_data_o), .ack_data_oe_i(ack_data_oe_o),
    .cascade_code_i(cascade_code_o), .interrupt_acknowledge_n_o(interrupt_acknowledge_n_i));
task complete_run;
    begin
        $display("fails=%0d comparisons=%0d", fails, comparisons);
        if (fails == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    end
endtask
task chk(input [7:0] got, input [7:0] want);
    begin
        comparisons = comparisons + 1;
        if (got !== want) begin
            fails = fails + 1;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, want);
        end
    end
endtask
task wr(input [7:0] a, input [7:0] d);
    begin
        @(posedge mclk_i);
        #1 {io_addr_i, io_wdata_i, io_wr_i} = {a, d, 1'b1};
        @(posedge mclk_i);
        #1 io_wr_i = 1'b0;
    end
endtask
task rd(input [7:0] a, input [7:0] want);
    begin
        @(posedge mclk_i);
        #1 {io_addr_i, io_rd_i} = {a, 1'b1};
        @(posedge mclk_i);
        #1 io_rd_i = 1'b0;
        chk(io_rdata_o, want);
        chk(io_rdata_oe_o, 1'b1);
    end
endtask
task init(input [7:0] b, input [7:0] v, input [7:0] c, input [7:0] m);
    begin
        wr(b, 8'h11);
        wr(b + 8'h01, v);
        wr(b + 8'h01, c);
        wr(b + 8'h01, m);
    end
endtask
// Bounded wait for the request, then a full two-pulse acknowledge
task ackw;
    begin
        repeat (40) if (int_o !== 1'b1) @(posedge mclk_i);
        i_host.run(vec, seen, code);
    end
endtask
always @(posedge mclk_i) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
        fails = fails + 1;
        complete_run;
    end
end
initial begin
    repeat (16) @(posedge mclk_i);
    #1 rst_i = 1'b0;
    chk({master_auto_eoi_o, master_special_nest_o, slave_auto_eoi_o, slave_special_nest_o}, 8'h00);
    init(8'h20, 8'h08, 8'h04, 8'h11);
    init(8'ha0, 8'h70, 8'h02, 8'h03);
    // Mode outputs are registered one cycle behind the mode word
    @(posedge mclk_i);
    #1 chk({master_auto_eoi_o, master_special_nest_o, slave_auto_eoi_o, slave_special_nest_o}, 8'h06);
    rd(8'h21, 8'h00);
    wr(8'h21, 8'ha5);
    rd(8'h21, 8'ha5);
    wr(8'ha1, 8'h5a);
    rd(8'ha1, 8'h5a);
    wr(8'h21, 8'h00);
    wr(8'ha1, 8'h00);
    for (n = 0; n < 16; n = n + 1) if (n != 2) begin
        irq_i[n] = 1'b1;
        ackw;
        chk(vec, {(n < 8) ? 5'h01 : 5'h0e, n[2:0]});
        chk(code, (n < 8) ? 3'h0 : 3'h2);
        irq_i[n] = 1'b0;
        eoi_clear_master_i = (n < 8) ? 8'h01 << n[2:0] : 8'h04;
        eoi_clear_slave_i = (n < 8) ? 8'h00 : 8'h01 << n[2:0];
        @(posedge mclk_i);
        #1 {eoi_clear_master_i, eoi_clear_slave_i} = 16'h0000;
    end
    wr(8'h21, 8'h04);
    irq_i[9] = 1'b1;
    repeat (20) @(posedge mclk_i);
    chk(int_o, 1'b0);
    #1 irq_i[6] = 1'b1;
    ackw;
    chk(vec, 8'h0e);
    // Lines 6 and 9 stay high across setup: no fresh edge, no request
    init(8'h20, 8'h08, 8'h04, 8'h01);
    init(8'ha0, 8'h70, 8'h03, 8'h01);
    rd(8'h21, 8'h00);
    repeat (20) @(posedge mclk_i);
    chk(int_o, 1'b0);
    #1 irq_i = 16'h0000;
    repeat (5) @(posedge mclk_i);
    #1 irq_i[12] = 1'b1;
    ackw;
    chk(seen, 1'b0);
    complete_run;
end
endmodule // tb_cascade_irq_setup
bind cascade_irq_setup cascade_irq_checker i_chk (.*);
